// file: src/vepc_top.sv
// pixel port, sync pins, rtc/subcarrier reset and teletext request logic
`include "vepc_defs.svh"
module vepc_top #(
    parameter int PIPE = `VEPC_PIPE_DELAY,
    parameter int DEPTH = `VEPC_FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] pixel_bus_i,
    input wire logic blank_n_i,
    input wire logic master_mode_i,
    input wire logic sync_mode2_i,
    input wire logic hsync_i,
    output logic hsync_o,
    output logic hsync_oe_o,
    input wire logic field_vsync_i,
    output logic field_vsync_o,
    output logic field_vsync_oe_o,
    input wire logic rtc_pin_cfg_hi_i,
    input wire logic rtc_pin_cfg_lo_i,
    input wire logic subcarrier_reset_or_rtc_in_i,
    input wire logic addr_select_in_i,
    input wire logic teletext_sel_i,
    input wire logic teletext_data_in_i,
    input wire logic teletext_window_i,
    input wire logic out_ready_i,
    output logic teletext_request_out_o,
    output logic [6:0] slave_addr_o,
    output logic [23:0] video_o,
    output logic video_valid_o,
    output logic pix_ready_o,
    output logic [21:0] rtc_subcarrier_o,
    output logic rtc_word_o,
    output logic [1:0] field_seq_o,
    output logic sc_reset_pulse_o,
    output logic teletext_bit_o,
    output logic std_pal_o,
    output logic [1:0] timing_mode_o,
    output logic [2:0] dac_en_o
);
    initial begin
        if (PIPE < 2) $error("pipeline too short");
    end
    // ========================================
    // defaults after reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            std_pal_o <= `VEPC_DEF_STD;
            timing_mode_o <= `VEPC_DEF_TMODE;
            dac_en_o <= `VEPC_DEF_DAC_EN;
        end
    end
    // address select strap, sampled on every clock after release
    localparam logic [6:0] ADDR_BASE = `VEPC_SLAVE_ADDR_BASE;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            slave_addr_o <= ADDR_BASE;
        end else begin
            slave_addr_o <= {ADDR_BASE[6:1], addr_select_in_i};
        end
    end
    // ========================================
    // pixel capture and demux
    vepc_pkg::vepc_phase_e ph_q;
    logic [7:0] cb_q;
    logic [7:0] cr_q;
    logic take;
    vepc_fifo_if #(.W(24)) wr_if ();
    vepc_fifo_if #(.W(24)) rd_if ();
    // limitation: a full fifo stalls capture, samples are not buffered upstream
    assign take = blank_n_i && wr_if.ready;
    assign pix_ready_o = wr_if.ready;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= vepc_pkg::VEPC_CB;
        end else if (!blank_n_i) begin
            ph_q <= vepc_pkg::VEPC_CB;
        end else if (take) begin
            unique case (ph_q)
                vepc_pkg::VEPC_CB: ph_q <= vepc_pkg::VEPC_Y0;
                vepc_pkg::VEPC_Y0: ph_q <= vepc_pkg::VEPC_CR;
                vepc_pkg::VEPC_CR: ph_q <= vepc_pkg::VEPC_Y1;
                vepc_pkg::VEPC_Y1: ph_q <= vepc_pkg::VEPC_CB;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cb_q <= `VEPC_CHROMA_MID;
            cr_q <= `VEPC_CHROMA_MID;
        end else if (take && ph_q == vepc_pkg::VEPC_CB) begin
            cb_q <= pixel_bus_i;
        end else if (take && ph_q == vepc_pkg::VEPC_CR) begin
            cr_q <= pixel_bus_i;
        end
    end
    assign wr_if.valid = take && (ph_q == vepc_pkg::VEPC_Y0 || ph_q == vepc_pkg::VEPC_Y1);
    assign wr_if.data = {cb_q, pixel_bus_i, cr_q};
    vepc_fifo #(.W(24), .D(DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr(wr_if),
        .rd(rd_if)
    );
    assign rd_if.ready = out_ready_i;
    // ========================================
    // fixed latency pipeline
    logic [24:0] pipe_q [PIPE];
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < PIPE; i++) begin
                pipe_q[i] <= '0;
            end
        end else begin
            pipe_q[0] <= {rd_if.valid && rd_if.ready, rd_if.data};
            for (int i = 1; i < PIPE; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end
    assign video_valid_o = pipe_q[PIPE-1][24];
    assign video_o = pipe_q[PIPE-1][23:0];
    // ========================================
    // timing generator and sync pins
    logic [11:0] hcnt_q;
    logic [9:0] lcnt_q;
    logic field_q;
    logic hs_in_q;
    logic hs_rise;
    logic run_q;
    assign hs_rise = hsync_i && !hs_in_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            // idle pin level is high, so no false edge follows reset
            hs_in_q <= 1'b1;
        end else begin
            run_q <= 1'b1;
            hs_in_q <= hsync_i;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hcnt_q <= '0;
            lcnt_q <= '0;
            field_q <= 1'b0;
        end else if (!master_mode_i && run_q && hs_rise) begin
            hcnt_q <= '0;
            if (sync_mode2_i) begin
                lcnt_q <= field_vsync_i ? '0 : lcnt_q + 1'b1;
            end else begin
                lcnt_q <= lcnt_q + 1'b1;
            end
            field_q <= sync_mode2_i ? field_q : field_vsync_i;
        end else if (hcnt_q == `VEPC_LINE_LEN - 12'h001) begin
            hcnt_q <= '0;
            if (lcnt_q == `VEPC_FIELD_LINES - 10'h001) begin
                lcnt_q <= '0;
                field_q <= !field_q;
            end else begin
                lcnt_q <= lcnt_q + 1'b1;
            end
        end else begin
            hcnt_q <= hcnt_q + 1'b1;
        end
    end
    assign hsync_oe_o = master_mode_i;
    assign field_vsync_oe_o = master_mode_i;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hsync_o <= 1'b1;
            field_vsync_o <= 1'b1;
        end else begin
            hsync_o <= !(hcnt_q < `VEPC_HS_WIDTH);
            field_vsync_o <= sync_mode2_i ? !(lcnt_q < `VEPC_VS_LINES) : field_q;
        end
    end
    // ========================================
    // subcarrier reset and rtc input
    logic [1:0] rtc_cfg;
    logic sc_in_q;
    logic sc_pend_q;
    logic sc_rise;
    logic field_prev_q;
    logic [1:0] bitclk_q;
    logic [6:0] bitcnt_q;
    logic [`VEPC_RTC_BITS-1:0] rtc_sh_q;
    assign rtc_cfg = {rtc_pin_cfg_hi_i, rtc_pin_cfg_lo_i};
    assign sc_rise = (rtc_cfg == `VEPC_RTC_CFG_SC_RST)
        && subcarrier_reset_or_rtc_in_i && !sc_in_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sc_in_q <= 1'b0;
            field_prev_q <= 1'b0;
        end else begin
            sc_in_q <= subcarrier_reset_or_rtc_in_i;
            field_prev_q <= field_q;
        end
    end
    // reset waits for next field start, as a mid-field jump would tear the burst
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sc_pend_q <= 1'b0;
            field_seq_o <= 2'h0;
            sc_reset_pulse_o <= 1'b0;
        end else begin
            sc_reset_pulse_o <= 1'b0;
            if (field_q != field_prev_q) begin
                if (sc_pend_q) begin
                    field_seq_o <= 2'h0;
                    sc_reset_pulse_o <= 1'b1;
                end else begin
                    field_seq_o <= field_seq_o + 2'h1;
                end
            end
            if (sc_rise) begin
                sc_pend_q <= 1'b1;
            end else if (field_q != field_prev_q) begin
                sc_pend_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bitclk_q <= '0;
            bitcnt_q <= '0;
            rtc_sh_q <= '0;
            rtc_subcarrier_o <= '0;
            rtc_word_o <= 1'b0;
        end else begin
            rtc_word_o <= 1'b0;
            if (rtc_cfg != `VEPC_RTC_CFG_RTC) begin
                bitclk_q <= '0;
                bitcnt_q <= '0;
            end else if (bitclk_q == `VEPC_RTC_CLK_PER_BIT - 1) begin
                bitclk_q <= '0;
                rtc_sh_q <= {subcarrier_reset_or_rtc_in_i, rtc_sh_q[`VEPC_RTC_BITS-1:1]};
                if (bitcnt_q == `VEPC_RTC_BITS - 1) begin
                    bitcnt_q <= '0;
                    rtc_subcarrier_o <= rtc_sh_q[`VEPC_RTC_SC_MSB+1:1];
                    rtc_word_o <= 1'b1;
                end else begin
                    bitcnt_q <= bitcnt_q + 7'h01;
                end
            end else begin
                bitclk_q <= bitclk_q + 2'h1;
            end
        end
    end
    // ========================================
    // teletext port
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            teletext_request_out_o <= 1'b0;
            teletext_bit_o <= 1'b0;
        end else begin
            teletext_request_out_o <= teletext_sel_i && teletext_window_i;
            teletext_bit_o <= teletext_sel_i ? teletext_data_in_i : 1'b0;
        end
    end
    // ========================================
    // checks
    property p_tt_low;
        @(posedge ref_clk_i) disable iff (rst_i) !teletext_sel_i |=> !teletext_request_out_o;
    endproperty
    a_tt_low: assert property (p_tt_low) else $error("teletext request high");
    property p_oe;
        @(posedge ref_clk_i) disable iff (rst_i) hsync_oe_o == master_mode_i && field_vsync_oe_o == master_mode_i;
    endproperty
    a_oe: assert property (p_oe) else $error("sync enable wrong");
    property p_latency;
        @(posedge ref_clk_i) disable iff (rst_i)
            (rd_if.valid && rd_if.ready) |-> ##`VEPC_PIPE_DELAY video_valid_o;
    endproperty
    a_latency: assert property (p_latency) else $error("latency not 48");
    property p_blank;
        @(posedge ref_clk_i) disable iff (rst_i)
            !blank_n_i |-> !wr_if.valid
                ##1 (ph_q == vepc_pkg::VEPC_CB && $stable(cb_q) && $stable(cr_q));
    endproperty
    a_blank: assert property (p_blank) else $error("capture during blank");
    property p_addr;
        @(posedge ref_clk_i) disable iff (rst_i) ##1 slave_addr_o[0] == $past(addr_select_in_i);
    endproperty
    a_addr: assert property (p_addr) else $error("address lsb wrong");
    property p_scr;
        @(posedge ref_clk_i) disable iff (rst_i)
            sc_reset_pulse_o |-> field_seq_o == 2'h0 && $past(sc_pend_q);
    endproperty
    a_scr: assert property (p_scr) else $error("subcarrier not at field 0");
    property p_sc_set;
        @(posedge ref_clk_i) disable iff (rst_i) sc_rise |=> sc_pend_q;
    endproperty
    a_sc_set: assert property (p_sc_set) else $error("subcarrier reset edge lost");
    property p_field_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
            (!master_mode_i && sync_mode2_i && run_q && hs_rise) |=> $stable(field_q);
    endproperty
    a_field_hold: assert property (p_field_hold) else $error("field changed in mode 2");
    property p_rtc_idle;
        @(posedge ref_clk_i) disable iff (rst_i) rtc_cfg != `VEPC_RTC_CFG_RTC |=> !rtc_word_o;
    endproperty
    a_rtc_idle: assert property (p_rtc_idle) else $error("rtc word while off");
    property p_dflt;
        @(posedge ref_clk_i) disable iff (rst_i) dac_en_o == `VEPC_DEF_DAC_EN && timing_mode_o == 2'h0;
    endproperty
    a_dflt: assert property (p_dflt) else $error("defaults lost");
    c_video: cover property (@(posedge ref_clk_i) disable iff (rst_i) video_valid_o);
    c_rtc: cover property (@(posedge ref_clk_i) disable iff (rst_i) rtc_word_o);
    c_scr: cover property (@(posedge ref_clk_i) disable iff (rst_i) sc_reset_pulse_o);
    c_slave: cover property (@(posedge ref_clk_i) disable iff (rst_i) !master_mode_i && run_q && hs_rise);
endmodule

// file: src/vepc_defs.svh
// constants and behaviour summary of the video encoder pin control block
// Behaviour
// - pixel bus carries multiplexed 4:2:2 bytes, bit zero is the lsb
// - master drives hsync pin; slave accepts it in sync modes 1 and 2
// - field/vsync pin: field in mode 1, vsync in mode 2; master drives it
// - pixel bus contents ignored while blanking input is low
// - two config bits set the rtc pin as subcarrier reset or rtc input
// - rising edge on subcarrier reset input resets subcarrier sequence to field 0
// - address select level sets serial slave address lsb
// - reset restores ntsc, slave mode 0, 8-bit, two composite, all dacs on
// - teletext request held low unless teletext insertion selected
// - pixel input to video output latency is 48 clock cycles; the code counts 48 from the fifo read, 49 from a y byte into an empty fifo
// - bytes captured on rising pixel clock edge
// - rtc word is 67 bits, bits 0 to 21 subcarrier, two clocks per bit
// - modes set over two-wire serial port at one of two addresses; no serial port here, modes keep reset values
`ifndef VEPC_DEFS_SVH
`define VEPC_DEFS_SVH
`define VEPC_PIPE_DELAY 48
`define VEPC_RTC_BITS 67
`define VEPC_RTC_SC_MSB 21
`define VEPC_RTC_CLK_PER_BIT 2
`define VEPC_SLAVE_ADDR_BASE 7'h2a
`define VEPC_FIFO_DEPTH 8
`define VEPC_LINE_LEN 12'h6b4
`define VEPC_HS_WIDTH 12'h080
`define VEPC_FIELD_LINES 10'h106
`define VEPC_VS_LINES 10'h003
`define VEPC_RTC_CFG_SC_RST 2'h1
`define VEPC_CHROMA_MID 8'h80
`define VEPC_RTC_CFG_RTC 2'h2
`define VEPC_DEF_STD 1'h0
`define VEPC_DEF_TMODE 2'h0
`define VEPC_DEF_DAC_EN 3'h7
`endif

// file: src/vepc_pkg.sv
// types of the video encoder pin control block
package vepc_pkg;
    typedef enum logic [1:0] {
        VEPC_CB,
        VEPC_Y0,
        VEPC_CR,
        VEPC_Y1
    } vepc_phase_e;
    typedef struct packed {
        logic [7:0] cb;
        logic [7:0] y;
        logic [7:0] cr;
    } vepc_pix_s;
endpackage

// file: src/vepc_fifo_if.sv
// stream interface between the capture logic and the fifo
interface vepc_fifo_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: src/vepc_fifo.sv
// parameterised fifo with valid/ready on both sides
module vepc_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    vepc_fifo_if.snk wr,
    vepc_fifo_if.src rd
);
    localparam int AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
    end
    logic [W-1:0] mem [D];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = wp_q == rp_q;
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rp_q[AW-1:0]];
    always_ff @(posedge ref_clk_i) begin
        if (wr.valid && !full) begin
            mem[wp_q[AW-1:0]] <= wr.data;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q <= '0;
        end else if (wr.valid && !full) begin
            wp_q <= wp_q + 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rp_q <= '0;
        end else if (rd.ready && !empty) begin
            rp_q <= rp_q + 1'b1;
        end
    end
    // a write into a full fifo is dropped, so occupancy never exceeds the depth
    property p_no_overflow;
        @(posedge ref_clk_i) disable iff (rst_i) (AW+1)'(wp_q - rp_q) <= (AW+1)'(D);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo holds more than its depth");
endmodule

// file: dv/vepc_src_model.sv
// pixel source model feeding cb,y,cr,y byte groups
module vepc_src_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic hide_i,
    input wire logic [3:0] groups_i,
    input wire logic [7:0] base_i,
    input wire logic pix_ready_i,
    output logic [7:0] pixel_bus_o,
    output logic blank_n_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] left_q;
    assign busy_o = left_q != 6'h00;
    // idle bus toggles every cycle so a stale byte never passes for data
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            left_q <= 6'h00;
            pixel_bus_o <= 8'h00;
            blank_n_o <= 1'b0;
        end else if (!busy_o) begin
            pixel_bus_o <= ~pixel_bus_o;
            blank_n_o <= 1'b0;
            if (go_i) begin
                left_q <= {groups_i, 2'b00};
                pixel_bus_o <= base_i;
                blank_n_o <= !hide_i;
            end
        end else if (!blank_n_o || pix_ready_i) begin
            left_q <= left_q - 6'h01;
            pixel_bus_o <= pixel_bus_o + 8'h01;
            blank_n_o <= !hide_i && left_q != 6'h01;
        end
    end
endmodule

// file: dv/tb_top.sv
// self-checking bench of the video encoder pin control block
`include "vepc_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PIPE = `VEPC_PIPE_DELAY;
    localparam logic [21:0] RV = 22'h2d3a5b;
    logic ref_clk_i, rst_i, go, hide, mm, m2, cfg_hi, cfg_lo, scr, asel, tsel, tdat, twin, ordy;
    logic [3:0] grp;
    logic [7:0] base, pix;
    logic blank_n, busy, hs_o, hs_oe, fv_o, fv_oe, ttreq, vval, prdy, rword, scp, tbit, pal;
    logic [6:0] saddr;
    logic [23:0] video;
    logic [21:0] rsc, rtc_seen;
    logic [1:0] fseq, tmode;
    logic [2:0] dac;
    logic [23:0] words [0:15];
    logic hs_drv, fv_drv;
    wire logic hs_pin = hs_oe ? hs_o : hs_drv;
    wire logic fv_pin = fv_oe ? fv_o : fv_drv;
    int mismatches, tests_run, cyc, nval, t_first, t_go, hs_low, n0, h0, n_scp;
    vepc_top #(.PIPE(PIPE), .DEPTH(`VEPC_FIFO_DEPTH)) i_dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pixel_bus_i(pix),
        .blank_n_i(blank_n),
        .master_mode_i(mm),
        .sync_mode2_i(m2),
        .hsync_i(hs_pin),
        .hsync_o(hs_o),
        .hsync_oe_o(hs_oe),
        .field_vsync_i(fv_pin),
        .field_vsync_o(fv_o),
        .field_vsync_oe_o(fv_oe),
        .rtc_pin_cfg_hi_i(cfg_hi),
        .rtc_pin_cfg_lo_i(cfg_lo),
        .subcarrier_reset_or_rtc_in_i(scr),
        .addr_select_in_i(asel),
        .teletext_sel_i(tsel),
        .teletext_data_in_i(tdat),
        .teletext_window_i(twin),
        .out_ready_i(ordy),
        .teletext_request_out_o(ttreq),
        .slave_addr_o(saddr),
        .video_o(video),
        .video_valid_o(vval),
        .pix_ready_o(prdy),
        .rtc_subcarrier_o(rsc),
        .rtc_word_o(rword),
        .field_seq_o(fseq),
        .sc_reset_pulse_o(scp),
        .teletext_bit_o(tbit),
        .std_pal_o(pal),
        .timing_mode_o(tmode),
        .dac_en_o(dac)
    );
    vepc_src_model i_src (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .go_i(go),
        .hide_i(hide),
        .groups_i(grp),
        .base_i(base),
        .pix_ready_i(prdy),
        .pixel_bus_o(pix),
        .blank_n_o(blank_n),
        .busy_o(busy)
    );
    // ==========================================
    // clock, monitor, tasks
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (vval === 1'b1) begin
            if (nval < 16) words[nval] <= video;
            if (nval == 0) t_first <= cyc;
            nval <= nval + 1;
        end
        if (rword === 1'b1) rtc_seen <= rsc;
        if (hs_o === 1'b0) hs_low <= hs_low + 1;
        if (scp === 1'b1) n_scp <= n_scp + 1;
    end
    // slave sync pulse: field level f, mode 2 select md, rising edge three clocks in
    task automatic hpulse(input logic f, input logic md);
        @(posedge ref_clk_i);
        fv_drv <= f;
        m2 <= md;
        hs_drv <= 1'b0;
        tick(2);
        hs_drv <= 1'b1;
        tick(4);
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // a blocked source gives up waiting after a bounded span, still busy
    task automatic send(input logic [3:0] g, input logic [7:0] b, input logic h);
        @(posedge ref_clk_i);
        t_go = cyc;
        grp <= g;
        base <= b;
        hide <= h;
        go <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        repeat (200) begin
            #1;
            if (busy === 1'b0) break;
            @(posedge ref_clk_i);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    // ==========================================
    // scenarios
    initial begin
        {go, hide, mm, m2, cfg_hi, cfg_lo, scr, asel, tsel, tdat, twin, ordy, fv_drv} = '0;
        {grp, base, mismatches, tests_run, cyc, nval, t_first, t_go, hs_low, n_scp} = '0;
        hs_drv = 1'b1;
        rst_i = 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        #1;
        cmp("slave_addr", 24'(`VEPC_SLAVE_ADDR_BASE), 24'(saddr));
        cmp("dac_en", 24'(`VEPC_DEF_DAC_EN), 24'(dac));
        cmp("std_pal", 24'(`VEPC_DEF_STD), 24'(pal));
        cmp("timing_mode", 24'(`VEPC_DEF_TMODE), 24'(tmode));
        cmp("hsync_oe", 24'h0, 24'(hs_oe));
        cmp("field_oe", 24'h0, 24'(fv_oe));
        asel <= 1'b1;
        twin <= 1'b1;
        tdat <= 1'b1;
        tick(3);
        #1;
        cmp("slave_addr", 24'(`VEPC_SLAVE_ADDR_BASE | 7'h01), 24'(saddr));
        cmp("tt_request", 24'h0, 24'(ttreq));
        tsel <= 1'b1;
        tick(3);
        #1;
        cmp("tt_request", 24'h1, 24'(ttreq));
        cmp("tt_bit", 24'h1, 24'(tbit));
        tsel <= 1'b0;
        ordy <= 1'b1;
        send(4'h1, 8'h40, 1'b0);
        tick(PIPE + 10);
        cmp("words", 24'h2, 24'(nval));
        cmp("word0", 24'h4041, 24'(words[0][23:8]));
        cmp("word1", 24'h404342, words[1]);
        cmp_rng("latency", PIPE + 2, PIPE + 6, t_first - t_go);
        n0 = nval;
        send(4'h2, 8'h80, 1'b1);
        tick(PIPE + 10);
        cmp("blank_words", 24'(n0), 24'(nval));
        ordy <= 1'b0;
        send(4'h4, 8'h10, 1'b0);
        send(4'h1, 8'h90, 1'b0);
        cmp("pix_ready", 24'h0, 24'(prdy));
        ordy <= 1'b1;
        tick(PIPE + 80);
        cmp("drained", 24'(`VEPC_FIFO_DEPTH + 2), 24'(nval - n0));
        cmp("drain0", 24'h1011, 24'(words[n0][23:8]));
        cmp("drain9", 24'h909392, words[n0 + 9]);
        cfg_hi <= 1'b1;
        for (int i = 0; i < `VEPC_RTC_BITS; i++) begin
            scr <= (i <= `VEPC_RTC_SC_MSB) ? RV[i] : 1'b0;
            tick(2);
        end
        tick(6);
        cmp("rtc_sc", 24'(RV), 24'(rtc_seen));
        cfg_hi <= 1'b0;
        cfg_lo <= 1'b1;
        hpulse(1'b1, 1'b0);
        cmp("field_seq", 24'h1, 24'(fseq));
        cmp("hsync_slave", 24'h0, 24'(hs_o));
        @(posedge ref_clk_i);
        scr <= 1'b1;
        hpulse(1'b0, 1'b0);
        cmp("field_seq", 24'h0, 24'(fseq));
        cmp("sc_resets", 24'h1, 24'(n_scp));
        hpulse(1'b1, 1'b1);
        cmp("vsync_out", 24'h0, 24'(fv_o));
        cmp("field_seq", 24'h0, 24'(fseq));
        repeat (3) hpulse(1'b0, 1'b1);
        cmp("vsync_out", 24'h1, 24'(fv_o));
        @(posedge ref_clk_i);
        mm <= 1'b1;
        tick(2);
        #1;
        cmp("hsync_oe", 24'h1, 24'(hs_oe));
        cmp("field_oe", 24'h1, 24'(fv_oe));
        h0 = hs_low;
        tick(`VEPC_LINE_LEN);
        #1;
        cmp("hsync_low", 24'(`VEPC_HS_WIDTH), 24'(hs_low - h0));
        conclude();
    end
endmodule
